// file: verilog/fpc_top.sv
// fast pulse counter command controller with wishbone registers
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module fpc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic count_pulse_i,
    input wire logic count_down_i,
    output logic [31:0] out_pattern_o,
    output logic running_o
);
    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic enable;
        logic cam_en;
        logic [3:0] sel;
        logic [7:0] cmd;
        logic [15:0] sts;
        logic [15:0] fsts;
        logic [31:0] up_set;
        logic [31:0] lo_set;
        logic [31:0] up_out_set;
        logic [31:0] lo_out_set;
        logic [31:0] ovf_lim;
        logic [31:0] unf_lim;
        logic [31:0] acc_cfg;
        logic [31:0] acc;
        logic [31:0] up_act;
        logic [31:0] lo_act;
        logic [31:0] up_pat;
        logic [31:0] lo_pat;
        logic [31:0] out_pat;
        logic [31:0] acc_snap;
        logic [5:0] flag_snap;
        logic running;
        logic [4:0] flags;
        logic [7:0] cam_len;
        logic [7:0] cam_idx;
        fpc_pkg::fpc_fetch_e fetch;
        logic [2:0] fcnt;
        logic [7:0] div;
        logic p_meta;
        logic p_sync;
        logic p_prev;
        logic d_meta;
        logic d_sync;
    } fpc_state_s;

    fpc_state_s st;
    fpc_state_s next_st;
    fpc_cam_if cam ();
    logic [4:0] act;
    logic [15:0] dec_sts;
    logic cfg_err;
    logic tick;

    fpc_cam_mem u_mem (
        .clk_i(clk_i),
        .cam(cam.mem)
    );

    fpc_cmd_decode u_dec (
        .cmd_i(st.cmd),
        .enable_i(st.enable),
        .sel_ok_i(fpc_pkg::fpc_sel_ok(st.sel)),
        .cfg_err_i(cfg_err),
        .running_i(st.running),
        .act_o(act),
        .sts_o(dec_sts)
    );

    // ********************************
    // evaluation and configuration checks
    // ********************************
    assign tick = (st.div == fpc_pkg::EVAL_LAST);
    // a run with the cam table on and no elements is a configuration error
    assign cfg_err = ((st.cmd == fpc_pkg::CMD_RUN) && st.cam_en && (st.cam_len == 8'h00))
        || ((st.cmd == fpc_pkg::CMD_LOAD)
        && (($signed(st.up_set) > $signed(st.ovf_lim))
        || ($signed(st.lo_set) < $signed(st.unf_lim))));

    // ********************************
    // next state
    // ********************************
    always_comb begin
        logic req;
        logic wr;
        logic rise;
        logic [31:0] nacc;
        logic [4:0] fv;
        logic adv;
        req = wb_cyc_i && wb_stb_i;
        wr = req && st.ack && wb_we_i;
        rise = st.p_sync && !st.p_prev;
        nacc = '0;
        fv = '0;
        adv = 1'b0;
        next_st = st;
        cam.wr_en = 1'b0;
        // cam words from byte 0x400 land at word 0, element e word w at e*4+w,
        // so only the first 64 elements fit the bus window
        cam.wr_addr = {2'b00, wb_adr_i[9:2]};
        cam.wr_data = wb_dat_i;
        cam.rd_addr = {st.cam_idx, st.fcnt[1:0]};

        next_st.div = tick ? 8'h00 : 8'(st.div + 8'h01);
        next_st.p_meta = count_pulse_i;
        next_st.p_sync = st.p_meta;
        next_st.p_prev = st.p_sync;
        next_st.d_meta = count_down_i;
        next_st.d_sync = st.d_meta;

        // mirror the live count unless a reset command consumes the field
        if (tick && !act[fpc_pkg::ACT_RESET]) begin
            next_st.acc_cfg = st.acc;
        end

        // wishbone slave
        next_st.ack = req && !st.ack;
        if (req && !st.ack) begin
            case (wb_adr_i)
                fpc_pkg::OFS_CTRL: next_st.rdata = {20'h00000, st.sel, 6'h00, st.cam_en, st.enable};
                fpc_pkg::OFS_CMD: next_st.rdata = {24'h000000, st.cmd};
                fpc_pkg::OFS_STS: next_st.rdata = {16'h0000, st.sts};
                fpc_pkg::OFS_UP_SET: next_st.rdata = st.up_set;
                fpc_pkg::OFS_LO_SET: next_st.rdata = st.lo_set;
                fpc_pkg::OFS_UP_OUT: next_st.rdata = st.up_out_set;
                fpc_pkg::OFS_LO_OUT: next_st.rdata = st.lo_out_set;
                fpc_pkg::OFS_OVF_LIM: next_st.rdata = st.ovf_lim;
                fpc_pkg::OFS_UNF_LIM: next_st.rdata = st.unf_lim;
                fpc_pkg::OFS_ACC_CFG: next_st.rdata = st.acc_cfg;
                fpc_pkg::OFS_ACC_STS: next_st.rdata = st.acc_snap;
                fpc_pkg::OFS_FLAGS: next_st.rdata = {26'h0000000, st.flag_snap};
                fpc_pkg::OFS_FLAGSET_STS: next_st.rdata = {16'h0000, st.fsts};
                fpc_pkg::OFS_CAM_LEN: next_st.rdata = {24'h000000, st.cam_len};
                fpc_pkg::OFS_CAM_IDX: next_st.rdata = {24'h000000, st.cam_idx};
                fpc_pkg::OFS_OUT: next_st.rdata = st.out_pat;
                default: next_st.rdata = 32'h00000000;
            endcase
        end
        if (wr) begin
            if (wb_adr_i[11:10] == fpc_pkg::CAM_REGION) begin
                cam.wr_en = (wb_sel_i == 4'hF);
            end
            case (wb_adr_i)
                fpc_pkg::OFS_CTRL: begin
                    if (wb_sel_i[0]) begin
                        next_st.enable = wb_dat_i[fpc_pkg::CTRL_EN];
                        next_st.cam_en = wb_dat_i[fpc_pkg::CTRL_CAM];
                    end
                    if (wb_sel_i[1]) begin
                        next_st.sel = wb_dat_i[fpc_pkg::SEL_LSB +: 4];
                    end
                end
                fpc_pkg::OFS_CMD: if (wb_sel_i[0]) next_st.cmd = wb_dat_i[7:0];
                fpc_pkg::OFS_UP_SET: next_st.up_set = fpc_pkg::fpc_merge(st.up_set, wb_dat_i, wb_sel_i);
                fpc_pkg::OFS_LO_SET: next_st.lo_set = fpc_pkg::fpc_merge(st.lo_set, wb_dat_i, wb_sel_i);
                fpc_pkg::OFS_UP_OUT:
                    next_st.up_out_set = fpc_pkg::fpc_merge(st.up_out_set, wb_dat_i, wb_sel_i);
                fpc_pkg::OFS_LO_OUT:
                    next_st.lo_out_set = fpc_pkg::fpc_merge(st.lo_out_set, wb_dat_i, wb_sel_i);
                fpc_pkg::OFS_OVF_LIM:
                    next_st.ovf_lim = fpc_pkg::fpc_merge(st.ovf_lim, wb_dat_i, wb_sel_i);
                fpc_pkg::OFS_UNF_LIM:
                    next_st.unf_lim = fpc_pkg::fpc_merge(st.unf_lim, wb_dat_i, wb_sel_i);
                fpc_pkg::OFS_ACC_CFG:
                    next_st.acc_cfg = fpc_pkg::fpc_merge(st.acc_cfg, wb_dat_i, wb_sel_i);
                fpc_pkg::OFS_CAM_LEN: if (wb_sel_i[0]) next_st.cam_len = wb_dat_i[7:0];
                fpc_pkg::OFS_FLAGSET: begin
                    if (!wb_dat_i[fpc_pkg::FLAGSET_EN]) begin
                        next_st.fsts = fpc_pkg::STS_IDLE;
                    end else if (!fpc_pkg::fpc_sel_ok(wb_dat_i[fpc_pkg::SEL_LSB +: 4])) begin
                        next_st.fsts = fpc_pkg::STS_BAD_SEL;
                    end else begin
                        fv = wb_dat_i[4:0];
                        if (st.running) begin
                            fv[fpc_pkg::FLG_UP] = fv[fpc_pkg::FLG_UP] | st.flags[fpc_pkg::FLG_UP];
                            fv[fpc_pkg::FLG_LO] = fv[fpc_pkg::FLG_LO] | st.flags[fpc_pkg::FLG_LO];
                        end
                        next_st.flags = fv;
                        next_st.fsts = fpc_pkg::STS_OK;
                    end
                end
                default: begin
                end
            endcase
        end

        // level commands, evaluated on every tick
        if (tick) begin
            next_st.sts = dec_sts;
            if (act[fpc_pkg::ACT_RUN]) begin
                next_st.running = 1'b1;
                if (st.cam_en) begin
                    next_st.cam_idx = 8'h00;
                    next_st.fetch = fpc_pkg::FPC_FETCH;
                    next_st.fcnt = 3'h0;
                end
            end
            if (act[fpc_pkg::ACT_STOP]) begin
                next_st.running = 1'b0;
            end
            if (act[fpc_pkg::ACT_LOAD]) begin
                next_st.up_act = st.up_set;
                next_st.lo_act = st.lo_set;
                next_st.up_pat = st.up_out_set;
                next_st.lo_pat = st.lo_out_set;
            end
            if (act[fpc_pkg::ACT_RESET]) begin
                next_st.acc = st.acc_cfg;
                next_st.flags = '0;
            end
            if (act[fpc_pkg::ACT_REFRESH]) begin
                next_st.acc_snap = st.acc;
                next_st.flag_snap = {st.running, st.flags};
            end
        end

        // cam element fetch, four words
        case (st.fetch)
            fpc_pkg::FPC_IDLE: begin
            end
            fpc_pkg::FPC_FETCH: begin
                next_st.fcnt = 3'(st.fcnt + 3'h1);
                case (st.fcnt)
                    3'h1: next_st.up_act = cam.rd_data;
                    3'h2: next_st.lo_act = cam.rd_data;
                    3'h3: next_st.up_pat = cam.rd_data;
                    3'h4: next_st.lo_pat = cam.rd_data;
                    default: begin
                    end
                endcase
                if (st.fcnt == fpc_pkg::FETCH_LAST) begin
                    next_st.fetch = fpc_pkg::FPC_IDLE;
                end
            end
            default: next_st.fetch = fpc_pkg::FPC_IDLE;
        endcase

        // counting; runs on regardless of the block enable
        if (st.running && rise && !(tick && act[fpc_pkg::ACT_RESET])) begin
            nacc = st.d_sync ? 32'(st.acc - 32'h00000001) : 32'(st.acc + 32'h00000001);
            next_st.acc = nacc;
            if (!st.d_sync && ($signed(nacc) > $signed(st.ovf_lim))) begin
                next_st.flags[fpc_pkg::FLG_OVF] = 1'b1;
                next_st.acc = 32'h00000000;
            end else if (st.d_sync && ($signed(nacc) < $signed(st.unf_lim))) begin
                next_st.flags[fpc_pkg::FLG_UNF] = 1'b1;
                next_st.acc = 32'h00000000;
            end else if (!st.d_sync && (nacc == st.up_act)) begin
                next_st.flags[fpc_pkg::FLG_UP] = 1'b1;
                next_st.out_pat = st.up_pat;
                adv = 1'b1;
            end else if (st.d_sync && (nacc == st.lo_act)) begin
                next_st.flags[fpc_pkg::FLG_LO] = 1'b1;
                next_st.out_pat = st.lo_pat;
                adv = 1'b1;
            end
        end
        if (adv && st.cam_en && (st.fetch == fpc_pkg::FPC_IDLE)) begin
            if ({1'b0, st.cam_idx} + 9'h001 >= {1'b0, st.cam_len}) begin
                next_st.cam_idx = 8'h00;
            end else begin
                next_st.cam_idx = 8'(st.cam_idx + 8'h01);
            end
            next_st.fetch = fpc_pkg::FPC_FETCH;
            next_st.fcnt = 3'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.fetch <= fpc_pkg::FPC_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign wb_dat_o = st.rdata;
    assign wb_ack_o = st.ack;
    assign out_pattern_o = st.out_pat;
    assign running_o = st.running;
endmodule // fpc_top

// file: verilog/fpc_pkg.sv
// constants, types and helpers of the fast pulse counter command controller
package fpc_pkg;
    // ********************************
    // timing
    // ********************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int EVAL_PERIOD_NS = 1000;
    localparam int EVAL_CYCLES = EVAL_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [7:0] EVAL_LAST = 8'(EVAL_CYCLES - 1);

    // ********************************
    // commands, status codes, actions
    // ********************************
    localparam logic [7:0] CMD_RUN = 8'h01;
    localparam logic [7:0] CMD_STOP = 8'h02;
    localparam logic [7:0] CMD_LOAD = 8'h03;
    localparam logic [7:0] CMD_RESET = 8'h04;
    localparam logic [15:0] STS_IDLE = 16'h0000;
    localparam logic [15:0] STS_OK = 16'h0001;
    localparam logic [15:0] STS_BAD_CMD = 16'h0002;
    localparam logic [15:0] STS_BAD_SEL = 16'h0003;
    localparam logic [15:0] STS_CFG_ERR = 16'h0004;
    localparam int ACT_RUN = 0;
    localparam int ACT_STOP = 1;
    localparam int ACT_LOAD = 2;
    localparam int ACT_RESET = 3;
    localparam int ACT_REFRESH = 4;
    localparam logic [3:0] CTR_COUNT = 4'h1;

    // ********************************
    // register map and fields
    // ********************************
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CMD = 12'h004;
    localparam logic [11:0] OFS_STS = 12'h008;
    localparam logic [11:0] OFS_UP_SET = 12'h00C;
    localparam logic [11:0] OFS_LO_SET = 12'h010;
    localparam logic [11:0] OFS_UP_OUT = 12'h014;
    localparam logic [11:0] OFS_LO_OUT = 12'h018;
    localparam logic [11:0] OFS_OVF_LIM = 12'h01C;
    localparam logic [11:0] OFS_UNF_LIM = 12'h020;
    localparam logic [11:0] OFS_ACC_CFG = 12'h024;
    localparam logic [11:0] OFS_ACC_STS = 12'h028;
    localparam logic [11:0] OFS_FLAGS = 12'h02C;
    localparam logic [11:0] OFS_FLAGSET = 12'h030;
    localparam logic [11:0] OFS_FLAGSET_STS = 12'h034;
    localparam logic [11:0] OFS_CAM_LEN = 12'h038;
    localparam logic [11:0] OFS_CAM_IDX = 12'h03C;
    localparam logic [11:0] OFS_OUT = 12'h040;
    localparam logic [1:0] CAM_REGION = 2'b01;
    localparam int CTRL_EN = 0;
    localparam int CTRL_CAM = 1;
    localparam int SEL_LSB = 8;
    localparam int FLG_DONE = 0;
    localparam int FLG_UP = 1;
    localparam int FLG_LO = 2;
    localparam int FLG_OVF = 3;
    localparam int FLG_UNF = 4;
    localparam int FLG_RUNNING = 5;
    localparam int FLAGSET_EN = 16;
    localparam int CAM_AW = 10;
    localparam int CAM_WORDS = 1024;
    localparam logic [2:0] FETCH_LAST = 3'h4;

    typedef enum logic [1:0] {
        FPC_IDLE = 2'b01,
        FPC_FETCH = 2'b10
    } fpc_fetch_e;

    // byte-lane merge of a wishbone write
    function automatic logic [31:0] fpc_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // counter selector check shared by both entries
    function automatic logic fpc_sel_ok(input logic [3:0] sel);
        return sel < CTR_COUNT;
    endfunction
endpackage

// file: verilog/fpc_cam_if.sv
// cam table memory port group
`timescale 1ns/1ps
interface fpc_cam_if;
    logic wr_en;
    logic [9:0] wr_addr;
    logic [31:0] wr_data;
    logic [9:0] rd_addr;
    logic [31:0] rd_data;
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface

// file: verilog/fpc_cam_mem.sv
// cam table storage with registered read data
`timescale 1ns/1ps
module fpc_cam_mem (
    input wire logic clk_i,
    fpc_cam_if.mem cam
);
    logic [31:0] store [0:fpc_pkg::CAM_WORDS-1];
    logic [31:0] rd_q;

    always_ff @(posedge clk_i) begin
        if (cam.wr_en) begin
            store[cam.wr_addr] <= cam.wr_data;
        end
        rd_q <= store[cam.rd_addr];
    end

    assign cam.rd_data = rd_q;
endmodule // fpc_cam_mem

// file: verilog/fpc_cmd_decode.sv
// command decoder: actions and execution status
`timescale 1ns/1ps
module fpc_cmd_decode (
    input wire logic [7:0] cmd_i,
    input wire logic enable_i,
    input wire logic sel_ok_i,
    input wire logic cfg_err_i,
    input wire logic running_i,
    output logic [4:0] act_o,
    output logic [15:0] sts_o
);
    always_comb begin
        act_o = '0;
        sts_o = fpc_pkg::STS_IDLE;
        if (!enable_i) begin
            act_o[fpc_pkg::ACT_REFRESH] = (cmd_i == fpc_pkg::CMD_RUN);
        end else if (!sel_ok_i) begin
            sts_o = fpc_pkg::STS_BAD_SEL;
        end else begin
            case (cmd_i)
                fpc_pkg::CMD_RUN: begin
                    if (cfg_err_i) begin
                        sts_o = fpc_pkg::STS_CFG_ERR;
                    end else begin
                        act_o[fpc_pkg::ACT_RUN] = !running_i;
                        act_o[fpc_pkg::ACT_REFRESH] = 1'b1;
                        sts_o = fpc_pkg::STS_OK;
                    end
                end
                fpc_pkg::CMD_STOP: begin
                    act_o[fpc_pkg::ACT_STOP] = running_i;
                    act_o[fpc_pkg::ACT_REFRESH] = 1'b1;
                    sts_o = fpc_pkg::STS_OK;
                end
                fpc_pkg::CMD_LOAD: begin
                    if (cfg_err_i) begin
                        sts_o = fpc_pkg::STS_CFG_ERR;
                    end else begin
                        act_o[fpc_pkg::ACT_LOAD] = 1'b1;
                        act_o[fpc_pkg::ACT_REFRESH] = 1'b1;
                        sts_o = fpc_pkg::STS_OK;
                    end
                end
                fpc_pkg::CMD_RESET: begin
                    act_o[fpc_pkg::ACT_RESET] = 1'b1;
                    act_o[fpc_pkg::ACT_REFRESH] = 1'b1;
                    sts_o = fpc_pkg::STS_OK;
                end
                default: begin
                    sts_o = fpc_pkg::STS_BAD_CMD;
                end
            endcase
        end
    end
endmodule // fpc_cmd_decode

// file: test/fpc_top_assertions.sv
// port checker of the command controller
`timescale 1ns/1ps
module fpc_top_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [31:0] out_pattern_o,
    input wire logic running_o
);
    logic [7:0] cmd_q;
    logic en_q;
    logic wr;
    logic rd;
    assign wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
    assign rd = wb_ack_o && !wb_we_i;
    // held command and enable, as written by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_q <= 8'h00;
            en_q <= 1'b0;
        end else if (wr && wb_adr_i == fpc_pkg::OFS_CMD) begin
            cmd_q <= wb_dat_i[7:0];
        end else if (wr && wb_adr_i == fpc_pkg::OFS_CTRL) begin
            en_q <= wb_dat_i[0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_rst; disable iff (1'b0) rst_i |=> !wb_ack_o && !running_o && out_pattern_o == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack one cycle after request");
    property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
    property p_no_req; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
    a_no_req: assert property (p_no_req) else $error("ack without request");
    property p_run; $rose(running_o) |-> $past(cmd_q) == fpc_pkg::CMD_RUN && $past(en_q); endproperty
    a_run: assert property (p_run) else $error("counting began without enabled run");
    property p_stop; $fell(running_o) |-> $past(cmd_q) == fpc_pkg::CMD_STOP && $past(en_q); endproperty
    a_stop: assert property (p_stop) else $error("counting ended without enabled stop");
    property p_sts; rd && wb_adr_i == fpc_pkg::OFS_STS |-> wb_dat_o <= 32'h4; endproperty
    a_sts: assert property (p_sts) else $error("status code out of set");
    property p_fsts; rd && wb_adr_i == fpc_pkg::OFS_FLAGSET_STS |-> wb_dat_o inside {0, 1, 3}; endproperty
    a_fsts: assert property (p_fsts) else $error("bad flag entry status");
    c_run: cover property ($rose(running_o));
    c_stop: cover property ($fell(running_o));
    c_sts: cover property (rd && wb_adr_i == fpc_pkg::OFS_STS);
endmodule // fpc_top_assertions
bind fpc_top fpc_top_assertions i_fpc_top_assertions (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .out_pattern_o(out_pattern_o), .running_o(running_o));

// file: test/testbench.sv
// self-checking bench of the command controller
`timescale 1ns/1ps
module testbench;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, run, pin = 1'b0;
    logic dn = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'hF;
    logic [31:0] dat = 32'h0, dato, pat;
    logic [7:0] bad[3] = '{8'h00, 8'h05, 8'hFF};
    int bad_count = 0, n_checks = 0, cyc_n = 0;
    fpc_top i_fpc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato),
        .wb_ack_o(ack), .count_pulse_i(pin), .count_down_i(dn), .out_pattern_o(pat),
        .running_o(run));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic summarize;
        if (bad_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 10000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("Error at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        acc(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic tk;
        repeat (110) @(posedge clk_i);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            pin <= 1'b1;
            repeat (4) @(posedge clk_i);
            pin <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(fpc_pkg::OFS_STS, 32'h0);
        rc(12'h0FC, 32'h0);
        wr(fpc_pkg::OFS_CMD, 32'h1);
        tk();
        rc(fpc_pkg::OFS_STS, 32'h0);
        chk(run, 1'b0);
        wr(fpc_pkg::OFS_CMD, 32'h0);
        wr(fpc_pkg::OFS_CTRL, 32'h1);
        foreach (bad[i]) begin
            wr(fpc_pkg::OFS_CTRL, 32'h0);
            wr(fpc_pkg::OFS_CMD, {24'h0, bad[i]});
            wr(fpc_pkg::OFS_CTRL, 32'h1);
            tk();
            rc(fpc_pkg::OFS_STS, 32'h2);
        end
        wr(fpc_pkg::OFS_CTRL, 32'h0);
        wr(fpc_pkg::OFS_CMD, 32'h3);
        wr(fpc_pkg::OFS_UP_SET, 32'h10);
        wr(fpc_pkg::OFS_CTRL, 32'h101);
        tk();
        rc(fpc_pkg::OFS_STS, 32'h3);
        wr(fpc_pkg::OFS_CTRL, 32'h1);
        tk();
        rc(fpc_pkg::OFS_STS, 32'h4);
        wr(fpc_pkg::OFS_OVF_LIM, 32'h100);
        wr(fpc_pkg::OFS_UNF_LIM, 32'hFFFFFF00);
        wr(fpc_pkg::OFS_LO_SET, 32'hFFFFFFF0);
        tk();
        rc(fpc_pkg::OFS_STS, 32'h1);
        wr(fpc_pkg::OFS_UP_OUT, 32'hA5);
        tk();
        wr(fpc_pkg::OFS_CTRL, 32'h0);
        wr(fpc_pkg::OFS_FLAGSET, 32'h1001F);
        rc(fpc_pkg::OFS_FLAGSET_STS, 32'h1);
        wr(fpc_pkg::OFS_CMD, 32'h1);
        tk();
        rc(fpc_pkg::OFS_FLAGS, 32'h1F);
        wr(fpc_pkg::OFS_FLAGSET, 32'h0);
        rc(fpc_pkg::OFS_FLAGSET_STS, 32'h0);
        tk();
        rc(fpc_pkg::OFS_FLAGS, 32'h1F);
        wr(fpc_pkg::OFS_CTRL, 32'h1);
        tk();
        chk(run, 1'b1);
        wr(fpc_pkg::OFS_FLAGSET, 32'h10000);
        tk();
        rc(fpc_pkg::OFS_FLAGS, 32'h26);
        pulse(3);
        tk();
        rc(fpc_pkg::OFS_ACC_CFG, 32'h3);
        wr(fpc_pkg::OFS_CTRL, 32'h0);
        tk();
        chk(run, 1'b1);
        wr(fpc_pkg::OFS_CMD, 32'h2);
        tk();
        chk(run, 1'b1);
        wr(fpc_pkg::OFS_CTRL, 32'h1);
        for (int i = 0; i < 200 && run !== 1'b0; i++) @(posedge clk_i);
        chk(run, 1'b0);
        wr(fpc_pkg::OFS_ACC_CFG, 32'hF);
        wr(fpc_pkg::OFS_CTRL, 32'h0);
        wr(fpc_pkg::OFS_CMD, 32'h4);
        wr(fpc_pkg::OFS_CTRL, 32'h1);
        repeat (60) @(posedge clk_i);
        wr(fpc_pkg::OFS_CTRL, 32'h0);
        wr(fpc_pkg::OFS_CMD, 32'h1);
        wr(fpc_pkg::OFS_CTRL, 32'h1);
        tk();
        chk(run, 1'b1);
        rc(fpc_pkg::OFS_ACC_CFG, 32'hF);
        rc(fpc_pkg::OFS_FLAGS, 32'h20);
        pulse(1);
        chk(pat, 32'hA5);
        wr(fpc_pkg::OFS_CTRL, 32'h0);
        wr(fpc_pkg::OFS_CMD, 32'h2);
        wr(fpc_pkg::OFS_CTRL, 32'h1);
        for (int i = 0; i < 200 && run !== 1'b0; i++) @(posedge clk_i);
        chk(run, 1'b0);
        wr(12'h400, 32'h11);
        wr(12'h404, 32'h11);
        wr(12'h408, 32'hB1);
        wr(12'h40C, 32'hC1);
        wr(12'h410, 32'h12);
        wr(12'h418, 32'hB2);
        wr(fpc_pkg::OFS_CAM_LEN, 32'h2);
        wr(fpc_pkg::OFS_CTRL, 32'h2);
        wr(fpc_pkg::OFS_CMD, 32'h1);
        wr(fpc_pkg::OFS_CTRL, 32'h3);
        tk();
        pulse(1);
        chk(pat, 32'hB1);
        pulse(1);
        chk(pat, 32'hB2);
        rc(fpc_pkg::OFS_CAM_IDX, 32'h0);
        dn <= 1'b1;
        pulse(1);
        chk(pat, 32'hC1);
        summarize();
    end
endmodule // testbench
